// *** design/droop_ctl_if.sv ***
`timescale 1ns/1ps
// Carries the trigger and status lines between the register block and its timers
interface droop_ctl_if;
	logic swap_start;
	logic stage_off;
	logic rail_below;
	logic droop_seen;

	modport regs (output swap_start, output rail_below, input stage_off, input droop_seen);
	modport blank (input swap_start, output stage_off);
	modport filt (input rail_below, output droop_seen);
endinterface : droop_ctl_if

// *** design/droop_deglitch.sv ***
`timescale 1ns/1ps
module droop_deglitch #(
	parameter int unsigned CYCLES = 1250
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	droop_ctl_if.filt ctl
);
	localparam int W = $clog2(CYCLES + 1);

	logic [W-1:0] cnt_q, cnt_d;
	logic seen_q, seen_d;

	// ==========================================================
	// Deglitch filter
	// Any cycle above threshold restarts the count, so short dips never flag
	always_comb begin
		cnt_d = '0;
		seen_d = 1'b0;
		// RL14 fixed deglitch
		if (ctl.rail_below) begin
			if (cnt_q == W'(CYCLES)) begin
				cnt_d = cnt_q;
				seen_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 1'b1;
				seen_d = (cnt_q == W'(CYCLES - 1));
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cnt_q <= '0;
			seen_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			seen_q <= seen_d;
		end
	end

	assign ctl.droop_seen = seen_q;

endmodule : droop_deglitch

// *** design/droop_pkg.sv ***
// Contract
// RL1 - Droop threshold is six binary-weighted bits 7..2, 3200 mV down to 100 mV.
// RL2 - Threshold resets to 0x6c for two to four cells, 0x04 for one cell.
// RL3 - Tracking bit 1 makes threshold two copy threshold one; resets disabled.
// RL4 - Bit 0 enables fast role swap; reads zero after reset.
// RL5 - Fast swap enable rising turns power stage off about 50 us.
// RL6 - High-impedance enable forces the fast swap enable bit to zero.
// RL7 - Host should not change fast swap enable during reverse boost.
// RL8 - Boost writes outside 3 V to 24 V are ignored; old value kept.
// RL9 - Boost voltage is twelve weighted bits 13..2; bit 13 adds 16384 mV.
// RL10 - Boost voltage register resets to 09c4h.
// RL11 - Boost bits 15..14 written one is invalid; bits 1..0 do nothing.
// RL12 - Boost voltage is sum of set weights; lowest field bit adds 8 mV.
// RL13 - Droop threshold adds 3.2 V offset; one cell keeps low three bits.
// RL14 - Rail below threshold two for 5 us deglitch raises droop flag.
package droop_pkg;

	// ==========================================================
	// Register byte addresses on the serial bus
	localparam logic [7:0] BOOST_LO_ADDR = 8'h06;
	localparam logic [7:0] BOOST_HI_ADDR = 8'h07;
	localparam logic [7:0] DROOP_ADDR = 8'h3e;

	// ==========================================================
	// Reset values and field positions
	localparam logic [15:0] BOOST_RESET = 16'h09c4;
	localparam logic [7:0] DROOP_RESET_MULTI = 8'h6c;
	localparam logic [7:0] DROOP_RESET_SINGLE = 8'h04;
	localparam int BOOST_FIELD_LSB = 2;
	localparam int BOOST_FIELD_MSB = 13;
	localparam int DROOP_FIELD_LSB = 2;
	localparam int DROOP_TRACK_BIT = 1;
	localparam int DROOP_SWAP_BIT = 0;

	// ==========================================================
	// Voltage scaling
	localparam logic [14:0] BOOST_MIN_MV = 15'h0bb8;
	localparam logic [14:0] BOOST_MAX_MV = 15'h5dc0;
	localparam int BOOST_LSB_SHIFT = 3;
	localparam logic [13:0] THRESH_OFFSET_MV = 14'h0c80;
	localparam logic [13:0] THRESH_STEP_MV = 14'h0064;
	localparam logic [5:0] SINGLE_CELL_MASK = 6'h07;

	// ==========================================================
	// Timing
	localparam int CLK_MHZ = 250;
	localparam int DROOP_DEGLITCH_US = 5;
	localparam int DROOP_DEGLITCH_CYCLES = DROOP_DEGLITCH_US * CLK_MHZ;
	localparam int SWAP_BLANK_US = 50;
	localparam int SWAP_BLANK_CYCLES = SWAP_BLANK_US * CLK_MHZ;

	// ==========================================================
	// Serial engine states
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_RX = 5'b00010,
		ST_ACK = 5'b00100,
		ST_TX = 5'b01000,
		ST_MACK = 5'b10000
	} ser_state_e;

	typedef enum logic [2:0] {
		PH_ADDR = 3'h1,
		PH_PTR = 3'h2,
		PH_DATA = 3'h4
	} ser_phase_e;

endpackage : droop_pkg

// *** design/swap_blank_timer.sv ***
`timescale 1ns/1ps
module swap_blank_timer #(
	parameter int unsigned CYCLES = 12500
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	droop_ctl_if.blank ctl
);
	localparam int W = $clog2(CYCLES + 1);

	logic [W-1:0] cnt_q, cnt_d;
	logic off_q, off_d;

	// ==========================================================
	// Blanking window
	// A fresh trigger restarts the window rather than extending from the old one
	always_comb begin
		cnt_d = cnt_q;
		off_d = off_q;
		// RL5 power stage off
		if (ctl.swap_start) begin
			cnt_d = W'(CYCLES - 1);
			off_d = 1'b1;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
		end else begin
			off_d = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cnt_q <= '0;
			off_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			off_q <= off_d;
		end
	end

	assign ctl.stage_off = off_q;

endmodule : swap_blank_timer

// *** design/sys_droop_and_boost_volt_regs.sv ***
`timescale 1ns/1ps
module sys_droop_and_boost_volt_regs
	import droop_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h2a, // Bus address, value arbitrary
	parameter int unsigned SWAP_BLANK_LEN = SWAP_BLANK_CYCLES
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic cell_single,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic high_impedance_enable,
	input wire logic [5:0] sys_droop_thresh_one,
	input wire logic [13:0] sys_rail_mv,
	output logic [11:0] boost_dac_code,
	output logic fast_swap_enable,
	output logic power_stage_off,
	output logic [13:0] sys_droop_thresh_two_mv,
	output logic sys_droop_flag
);

	// ==========================================================
	// Bus line history
	logic scl_q, sda_q;
	logic scl_rise, scl_fall, bus_start, bus_stop;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	// Edges and bus conditions; data may only change while the clock is low
	assign scl_rise = scl_in & ~scl_q;
	assign scl_fall = ~scl_in & scl_q;
	assign bus_start = scl_in & scl_q & sda_q & ~sda_in;
	assign bus_stop = scl_in & scl_q & ~sda_q & sda_in;

	// ==========================================================
	// Serial engine
	ser_state_e st_q, st_d;
	ser_phase_e ph_q, ph_d;
	logic [7:0] shift_q, shift_d;
	logic [7:0] tx_q, tx_d;
	logic [7:0] ptr_q, ptr_d;
	logic [3:0] cnt_q, cnt_d;
	logic rd_q, rd_d;
	logic nack_q, nack_d;
	logic wr_stb;
	logic [7:0] rd_byte_cur, rd_byte_next;

	// Read data is picked at the moment a byte is loaded, not while it shifts
	function automatic logic [7:0] read_byte(input logic [7:0] addr,
		input logic [11:0] boost, input logic [7:0] droop);
		logic [7:0] val;
		val = 8'h00;
		case (addr)
			BOOST_LO_ADDR: val = {boost[5:0], 2'b00};
			BOOST_HI_ADDR: val = {2'b00, boost[11:6]};
			DROOP_ADDR: val = droop;
			default: val = 8'h00;
		endcase
		return val;
	endfunction : read_byte

	logic [11:0] boost_q, boost_d;
	logic [5:0] thresh_q, thresh_d;
	logic track_q, track_d;
	logic swap_q, swap_d;

	assign rd_byte_cur = read_byte(ptr_q, boost_q, {thresh_q, track_q, swap_q});
	assign rd_byte_next = read_byte(8'(ptr_q + 8'h01), boost_q, {thresh_q, track_q, swap_q});

	// Next state of the serial engine; start and stop override any byte in flight
	always_comb begin
		st_d = st_q;
		ph_d = ph_q;
		shift_d = shift_q;
		tx_d = tx_q;
		ptr_d = ptr_q;
		cnt_d = cnt_q;
		rd_d = rd_q;
		nack_d = nack_q;
		wr_stb = 1'b0;
		if (bus_start) begin
			st_d = ST_RX;
			ph_d = PH_ADDR;
			cnt_d = 4'h0;
		end else if (bus_stop) begin
			st_d = ST_IDLE;
		end else begin
			case (st_q)
				ST_IDLE: begin
					cnt_d = 4'h0;
				end
				ST_RX: begin
					if (scl_rise && cnt_q != 4'h8) begin
						shift_d = {shift_q[6:0], sda_in};
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == 4'h8) begin
						cnt_d = 4'h0;
						st_d = ST_ACK;
						case (ph_q)
							PH_ADDR: begin
								rd_d = shift_q[0];
								if (shift_q[7:1] != DEV_ADDR) begin
									st_d = ST_IDLE;
								end
							end
							PH_PTR: ptr_d = shift_q;
							default: wr_stb = 1'b1;
						endcase
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						st_d = ST_RX;
						if (ph_q == PH_ADDR && rd_q) begin
							st_d = ST_TX;
							tx_d = rd_byte_cur;
						end else if (ph_q == PH_ADDR) begin
							ph_d = PH_PTR;
						end else if (ph_q == PH_PTR) begin
							ph_d = PH_DATA;
						end else begin
							ptr_d = 8'(ptr_q + 8'h01);
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (cnt_q == 4'h7) begin
							cnt_d = 4'h0;
							st_d = ST_MACK;
						end else begin
							tx_d = {tx_q[6:0], 1'b0};
							cnt_d = cnt_q + 4'h1;
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						nack_d = sda_in;
					end else if (scl_fall) begin
						if (nack_q) begin
							st_d = ST_IDLE;
						end else begin
							st_d = ST_TX;
							ptr_d = 8'(ptr_q + 8'h01);
							tx_d = rd_byte_next;
						end
					end
				end
				default: st_d = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_q <= ST_IDLE;
			ph_q <= PH_ADDR;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			ptr_q <= 8'h00;
			cnt_q <= 4'h0;
			rd_q <= 1'b0;
			nack_q <= 1'b1;
		end else begin
			st_q <= st_d;
			ph_q <= ph_d;
			shift_q <= shift_d;
			tx_q <= tx_d;
			ptr_q <= ptr_d;
			cnt_q <= cnt_d;
			rd_q <= rd_d;
			nack_q <= nack_d;
		end
	end

	// Open-drain data line: only ever pulled low, released otherwise
	assign sda_out = 1'b0;
	assign sda_oe = (st_q == ST_ACK) || (st_q == ST_TX && !tx_q[7]);

	// ==========================================================
	// Boost voltage register
	// The low byte waits in a stage so a 16-bit write is judged as a whole
	logic [7:0] stage_q, stage_d;
	logic stage_pend_q, stage_pend_d;
	logic [15:0] cand;
	logic cand_take;
	logic [14:0] cand_mv;

	always_comb begin
		stage_d = stage_q;
		stage_pend_d = stage_pend_q;
		cand = {2'b00, boost_q, 2'b00};
		cand_take = 1'b0;
		if (wr_stb && ptr_q == BOOST_LO_ADDR) begin
			stage_d = shift_q;
			stage_pend_d = 1'b1;
		end else if (wr_stb && ptr_q == BOOST_HI_ADDR) begin
			cand = {shift_q, stage_pend_q ? stage_q : {boost_q[5:0], 2'b00}};
			cand_take = 1'b1;
			stage_pend_d = 1'b0;
		end else if (bus_stop && stage_pend_q) begin
			// Lone low-byte write commits when the transfer ends
			cand = {2'b00, boost_q[11:6], stage_q};
			cand_take = 1'b1;
			stage_pend_d = 1'b0;
		end
	end

	// RL12 sum of weights
	assign cand_mv = 15'(cand[BOOST_FIELD_MSB:BOOST_FIELD_LSB]) << BOOST_LSB_SHIFT;

	always_comb begin
		boost_d = boost_q;
		// RL8 range gate
		// RL11 reserved high bits
		if (cand_take && cand[15:14] == 2'b00 && cand_mv >= BOOST_MIN_MV
			&& cand_mv <= BOOST_MAX_MV) begin
			// RL9 field bits 13..2
			boost_d = cand[BOOST_FIELD_MSB:BOOST_FIELD_LSB];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			// RL10 reset value
			boost_q <= BOOST_RESET[BOOST_FIELD_MSB:BOOST_FIELD_LSB];
			stage_q <= 8'h00;
			stage_pend_q <= 1'b0;
		end else begin
			boost_q <= boost_d;
			stage_q <= stage_d;
			stage_pend_q <= stage_pend_d;
		end
	end

	assign boost_dac_code = boost_q;

	// ==========================================================
	// Droop threshold register
	logic single_q;
	logic swap_prev_q;
	logic [5:0] th2_code;
	logic [13:0] th2_mv_q, th2_mv_d;
	droop_ctl_if ctl ();

	always_comb begin
		thresh_d = thresh_q;
		track_d = track_q;
		swap_d = swap_q;
		if (wr_stb && ptr_q == DROOP_ADDR) begin
			// RL1 weighted field
			thresh_d = shift_q[7:DROOP_FIELD_LSB];
			// RL3 tracking bit
			track_d = shift_q[DROOP_TRACK_BIT];
			// RL4 swap enable bit
			swap_d = shift_q[DROOP_SWAP_BIT];
		end
		// RL6 high impedance wins
		if (high_impedance_enable) begin
			swap_d = 1'b0;
		end
	end

	// Strap is taken under the synchronous reset, so reset value follows the cell count
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			single_q <= cell_single;
			// RL2 strap-dependent reset
			thresh_q <= cell_single ? DROOP_RESET_SINGLE[7:DROOP_FIELD_LSB]
				: DROOP_RESET_MULTI[7:DROOP_FIELD_LSB];
			track_q <= 1'b0;
			swap_q <= 1'b0;
			swap_prev_q <= 1'b0;
		end else begin
			thresh_q <= thresh_d;
			track_q <= track_d;
			swap_q <= swap_d;
			swap_prev_q <= swap_q;
		end
	end

	// RL3 follow threshold one
	// RL13 single cell mask
	assign th2_code = (track_q ? sys_droop_thresh_one : thresh_q)
		& (single_q ? SINGLE_CELL_MASK : 6'h3f);

	// RL13 fixed offset
	assign th2_mv_d = 14'(THRESH_OFFSET_MV + 14'(th2_code) * THRESH_STEP_MV);

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			th2_mv_q <= THRESH_OFFSET_MV;
		end else begin
			th2_mv_q <= th2_mv_d;
		end
	end

	// ==========================================================
	// Timers
	// RL5 rising edge only
	assign ctl.swap_start = swap_q & ~swap_prev_q;
	// RL14 compare rail
	assign ctl.rail_below = sys_rail_mv < th2_mv_q;

	swap_blank_timer #(
		.CYCLES(SWAP_BLANK_LEN)
	) u_blank (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.ctl(ctl.blank)
	);

	droop_deglitch #(
		.CYCLES(DROOP_DEGLITCH_CYCLES)
	) u_deglitch (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.ctl(ctl.filt)
	);

	assign fast_swap_enable = swap_q;
	assign power_stage_off = ctl.stage_off;
	assign sys_droop_thresh_two_mv = th2_mv_q;
	assign sys_droop_flag = ctl.droop_seen;

endmodule : sys_droop_and_boost_volt_regs

// *** tb/i2c_host_model.sv ***
`timescale 1ns/1ps
module i2c_host_model (
	input wire logic ref_clk,
	output logic scl,
	output logic sda_pull,
	input wire logic sda_wire
);
	// ====================
	// Bus timing; each clock level spans three ref_clk cycles
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	task automatic hc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : hc

	// Data moves only while scl is low; the line is released to the pull-up for a one
	task automatic bit_io(input logic b, output logic got);
		sda_pull = ~b;
		hc(3);
		scl = 1'b1;
		hc(2);
		got = sda_wire;
		hc(1);
		scl = 1'b0;
	endtask : bit_io

	task automatic start_cond();
		sda_pull = 1'b0;
		hc(3);
		scl = 1'b1;
		hc(3);
		sda_pull = 1'b1;
		hc(3);
		scl = 1'b0;
	endtask : start_cond

	task automatic stop_cond();
		sda_pull = 1'b1;
		hc(3);
		scl = 1'b1;
		hc(3);
		sda_pull = 1'b0;
		hc(3);
	endtask : stop_cond

	// Eight bits then one acknowledge bit; reads send all ones so the line is free
	task automatic byte_io(input logic [7:0] b, input logic last, output logic [7:0] got,
		output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r);
			got[i] = r;
		end
		bit_io(last, r);
		ack = ~r;
	endtask : byte_io

	// One whole transfer: address, pointer, optional restart, n data bytes low first
	task automatic xfer(input logic [6:0] dev, input logic [7:0] ptr, input int n,
		input logic rd, input logic [15:0] wdata, output logic [15:0] rdata, output logic ok);
		logic [7:0] g;
		logic a;
		rdata = 16'h0000;
		start_cond();
		byte_io({dev, 1'b0}, 1'b1, g, ok);
		byte_io(ptr, 1'b1, g, a);
		ok = ok & a;
		if (rd) begin
			start_cond();
			byte_io({dev, 1'b1}, 1'b1, g, a);
			ok = ok & a;
		end
		for (int k = 0; k < n; k++) begin
			byte_io(rd ? 8'hff : wdata[8*k +: 8], rd ? (k == n - 1) : 1'b1, g, a);
			rdata[8*k +: 8] = g;
			if (!rd) ok = ok & a;
		end
		stop_cond();
	endtask : xfer
endmodule : i2c_host_model

// *** tb/sys_droop_and_boost_volt_regs_sva.sv ***
`timescale 1ns/1ps
module sys_droop_and_boost_volt_regs_sva #(
	parameter int unsigned BLANK_LEN = 20
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic cell_single,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic high_impedance_enable,
	input wire logic [5:0] sys_droop_thresh_one,
	input wire logic [13:0] sys_rail_mv,
	input wire logic [11:0] boost_dac_code,
	input wire logic fast_swap_enable,
	input wire logic power_stage_off,
	input wire logic [13:0] sys_droop_thresh_two_mv,
	input wire logic sys_droop_flag
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	// ====================
	// Helper counters
	logic [15:0] blank_cnt_q;
	logic [15:0] low_cnt_q;

	// Length of the current blanking pulse and of the current low-rail run
	always_ff @(posedge ref_clk) begin
		if (sys_rst || !power_stage_off) blank_cnt_q <= 16'h0000;
		else blank_cnt_q <= blank_cnt_q + 16'h0001;
		if (sys_rst || sys_rail_mv >= sys_droop_thresh_two_mv) low_cnt_q <= 16'h0000;
		else if (low_cnt_q != 16'hffff) low_cnt_q <= low_cnt_q + 16'h0001;
	end

	sequence swap_rise;
		!fast_swap_enable ##1 fast_swap_enable;
	endsequence
	sequence rail_ok;
		sys_droop_flag && sys_rail_mv >= sys_droop_thresh_two_mv;
	endsequence

	// ====================
	// Properties
	chk_reset_state: assert property ($fell(sys_rst) |-> boost_dac_code == 12'h271
		&& !fast_swap_enable && !power_stage_off && !sys_droop_flag && !sda_oe)
		else $error("outputs wrong after reset release");
	chk_impedance_clears_swap: assert property (high_impedance_enable |=> !fast_swap_enable)
		else $error("swap enable set while high impedance on");
	chk_swap_blank_start: assert property (swap_rise |=> power_stage_off)
		else $error("power stage not off after swap enable rose");
	chk_blank_cause: assert property ($rose(power_stage_off) |->
		$past(fast_swap_enable) && !$past(fast_swap_enable, 2))
		else $error("power stage off without swap enable rising");
	chk_blank_length: assert property ($fell(power_stage_off) |-> blank_cnt_q == BLANK_LEN)
		else $error("blanking pulse length wrong");
	chk_flag_deglitch: assert property ($rose(sys_droop_flag) |->
		low_cnt_q >= 16'h04e2 && low_cnt_q <= 16'h04e7)
		else $error("droop flag rose without full deglitch");
	chk_flag_release: assert property (rail_ok |-> ##[1:3] !sys_droop_flag)
		else $error("droop flag stuck after rail recovered");
	chk_boost_range: assert property (boost_dac_code >= 12'h177 && boost_dac_code <= 12'hbb8)
		else $error("boost code outside 3 V to 24 V");
	chk_thresh_span: assert property (sys_droop_thresh_two_mv >= 14'h0c80
		&& sys_droop_thresh_two_mv <= 14'h251c)
		else $error("threshold two outside its span");
	chk_single_cap: assert property (cell_single |-> sys_droop_thresh_two_mv <= 14'h0f3c)
		else $error("single cell threshold above 3.9 V");
	chk_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data line moved while clock high");
endmodule : sys_droop_and_boost_volt_regs_sva

// *** tb/tb_sys_droop_and_boost_volt_regs.sv ***
`timescale 1ns/1ps
module tb_sys_droop_and_boost_volt_regs;
	localparam logic [6:0] DEV = 7'h2a;
	logic ref_clk, sys_rst, cell_single, scl, sda_pull, sda_wire, sda_out, sda_oe;
	logic high_impedance_enable, fast_swap_enable, power_stage_off, sys_droop_flag;
	logic [5:0] thresh_one;
	logic [13:0] rail, thresh_two;
	logic [11:0] boost_dac_code;
	int failures = 0;
	int n_checks = 0;
	int off_cycles = 0;
	logic [15:0] d;

	// Open-drain data line with pull-up
	assign sda_wire = ~(sda_pull | (sda_oe & ~sda_out));

	sys_droop_and_boost_volt_regs #(.SWAP_BLANK_LEN(20)) dut_u (.ref_clk(ref_clk),
		.sys_rst(sys_rst), .cell_single(cell_single), .scl_in(scl), .sda_in(sda_wire),
		.sda_out(sda_out), .sda_oe(sda_oe), .high_impedance_enable(high_impedance_enable),
		.sys_droop_thresh_one(thresh_one), .sys_rail_mv(rail),
		.boost_dac_code(boost_dac_code), .fast_swap_enable(fast_swap_enable),
		.power_stage_off(power_stage_off), .sys_droop_thresh_two_mv(thresh_two),
		.sys_droop_flag(sys_droop_flag));
	i2c_host_model host_u (.ref_clk(ref_clk), .scl(scl), .sda_pull(sda_pull),
		.sda_wire(sda_wire));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) if (power_stage_off === 1'b1) off_cycles++;

	// ====================
	// Shared tasks
	task automatic give_verdict();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : give_verdict
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : step
	task automatic do_reset(input logic single);
		sys_rst = 1'b1;
		cell_single = single;
		step(12);
		sys_rst = 1'b0;
		step(2);
	endtask : do_reset
	task automatic wr(input logic [7:0] p, input int n, input logic [15:0] v);
		logic ok;
		host_u.xfer(DEV, p, n, 1'b0, v, d, ok);
		chk("write ack", 16'h0001, {15'h0000, ok});
	endtask : wr
	task automatic rd(input logic [7:0] p, input int n);
		logic ok;
		host_u.xfer(DEV, p, n, 1'b1, 16'h0000, d, ok);
		chk("read ack", 16'h0001, {15'h0000, ok});
	endtask : rd

	// ====================
	// Scenarios
	task automatic t_reset();
		rd(8'h3e, 1);
		chk("droop byte", 16'h006c, d);
		rd(8'h06, 2);
		chk("boost reg", 16'h09c4, d);
		chk("boost code", 16'h0271, {4'h0, boost_dac_code});
		chk("thresh two", 16'h170c, {2'b00, thresh_two});
	endtask : t_reset
	task automatic t_boost();
		logic [15:0] wv [6] = '{16'h05dc, 16'h05d8, 16'h2ee0, 16'h2ee4, 16'h45dc, 16'h05df};
		logic [15:0] ev [6] = '{16'h05dc, 16'h05dc, 16'h2ee0, 16'h2ee0, 16'h2ee0, 16'h05dc};
		for (int i = 0; i < 6; i++) begin
			wr(8'h06, 2, wv[i]);
			rd(8'h06, 2);
			chk("boost reg", ev[i], d);
			chk("boost code", {4'h0, ev[i][13:2]}, {4'h0, boost_dac_code});
		end
		wr(8'h06, 1, 16'h00e0);
		rd(8'h06, 2);
		chk("boost low only", 16'h05e0, d);
		wr(8'h07, 1, 16'h002e);
		rd(8'h06, 2);
		chk("boost high only", 16'h2ee0, d);
	endtask : t_boost
	task automatic t_droop();
		for (int i = 0; i < 6; i++) begin
			wr(8'h3e, 1, 16'h0004 << i);
			chk("thresh weight", 16'h0c80 + (16'h0064 << i), {2'b00, thresh_two});
		end
		thresh_one = 6'h0a;
		wr(8'h3e, 1, 16'h00fe);
		chk("thresh tracked", 16'h1068, {2'b00, thresh_two});
		thresh_one = 6'h3f;
		step(3);
		chk("thresh tracked", 16'h251c, {2'b00, thresh_two});
	endtask : t_droop
	// Swap enable is only touched with reverse boost idle
	task automatic t_swap();
		wr(8'h3e, 1, 16'h0001);
		step(30);
		chk("swap enable", 16'h0001, {15'h0000, fast_swap_enable});
		chk("blank cycles", 16'h0014, off_cycles[15:0]);
		high_impedance_enable = 1'b1;
		step(2);
		chk("swap forced off", 16'h0000, {15'h0000, fast_swap_enable});
		wr(8'h3e, 1, 16'h0001);
		rd(8'h3e, 1);
		chk("droop byte hiz", 16'h0000, d);
		chk("blank cycles", 16'h0014, off_cycles[15:0]);
		high_impedance_enable = 1'b0;
	endtask : t_swap
	task automatic t_flag();
		rail = 14'h0c7f;
		step(1200);
		chk("droop flag early", 16'h0000, {15'h0000, sys_droop_flag});
		step(60);
		chk("droop flag", 16'h0001, {15'h0000, sys_droop_flag});
		rail = 14'h0c80;
		step(3);
		chk("droop flag clear", 16'h0000, {15'h0000, sys_droop_flag});
	endtask : t_flag
	task automatic t_single();
		logic ok;
		do_reset(1'b1);
		rd(8'h3e, 1);
		chk("droop byte one cell", 16'h0004, d);
		chk("thresh one cell", 16'h0ce4, {2'b00, thresh_two});
		wr(8'h3e, 1, 16'h00fc);
		chk("thresh capped", 16'h0f3c, {2'b00, thresh_two});
		host_u.xfer(7'h15, 8'h3e, 1, 1'b0, 16'h0000, d, ok);
		chk("foreign address ack", 16'h0000, {15'h0000, ok});
		rd(8'h10, 1);
		chk("unmapped read", 16'h0000, d);
	endtask : t_single

	// ====================
	// Main sequence and watchdog
	initial begin
		sys_rst = 1'b1;
		cell_single = 1'b0;
		high_impedance_enable = 1'b0;
		thresh_one = 6'h00;
		rail = 14'h3fff;
		do_reset(1'b0);
		t_reset();
		t_boost();
		t_droop();
		t_swap();
		t_flag();
		t_single();
		give_verdict();
	end
	initial begin
		#200000;
		failures++;
		give_verdict();
	end
endmodule : tb_sys_droop_and_boost_volt_regs

bind sys_droop_and_boost_volt_regs sys_droop_and_boost_volt_regs_sva #(
	.BLANK_LEN(SWAP_BLANK_LEN)) chk_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.cell_single(cell_single), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .high_impedance_enable(high_impedance_enable),
	.sys_droop_thresh_one(sys_droop_thresh_one), .sys_rail_mv(sys_rail_mv),
	.boost_dac_code(boost_dac_code), .fast_swap_enable(fast_swap_enable),
	.power_stage_off(power_stage_off), .sys_droop_thresh_two_mv(sys_droop_thresh_two_mv),
	.sys_droop_flag(sys_droop_flag));
